// ---- inc/istim_consts.vh ----
`ifndef ISTIM_CONSTS_VH
`define ISTIM_CONSTS_VH

// ----------------------------------------
// Register byte addresses.
// ----------------------------------------
`define ISTIM_STD_HIGH_ADDR 32'h50001314
`define ISTIM_STD_LOW_ADDR 32'h50001318
`define ISTIM_FAST_HIGH_ADDR 32'h5000131C
`define ISTIM_FAST_LOW_ADDR 32'h50001320

// ----------------------------------------
// Reset values of the counts.
// ----------------------------------------
`define ISTIM_STD_HIGH_RESET 16'h0048
`define ISTIM_STD_LOW_RESET 16'h004F
`define ISTIM_FAST_HIGH_RESET 16'h0008
`define ISTIM_FAST_LOW_RESET 16'h0017

// ----------------------------------------
// Least stored values and idle margin.
// ----------------------------------------
`define ISTIM_HIGH_MIN 16'h0006
`define ISTIM_LOW_MIN 16'h0008
`define ISTIM_IDLE_MARGIN 16'h000A

// ----------------------------------------
// Field layout of a count register.
// ----------------------------------------
`define ISTIM_COUNT_MSB 15
`define ISTIM_LOW_BYTE_MSB 7
`define ISTIM_HIGH_BYTE_LSB 8

`endif

// ---- rtl/istim_count_store.v ----
`timescale 1ns/1ps
`default_nettype none
`include "istim_consts.vh"

module istim_count_store #(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] RESET_VALUE = `ISTIM_STD_HIGH_RESET,
    parameter [WIDTH-1:0] MIN_VALUE = `ISTIM_HIGH_MIN
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Write side.
    input wire wr_en,
    input wire [1:0] wr_be,
    input wire [WIDTH-1:0] wr_data,
    // Stored count.
    output reg [WIDTH-1:0] count_reg
);

    // ----------------------------------------
    // Byte merge and clamp.
    // ----------------------------------------
    wire [WIDTH-1:0] merged;
    wire [WIDTH-1:0] count_next;

    assign merged = {wr_be[1] ? wr_data[WIDTH-1:`ISTIM_HIGH_BYTE_LSB] :
                                count_reg[WIDTH-1:`ISTIM_HIGH_BYTE_LSB],
                     wr_be[0] ? wr_data[`ISTIM_LOW_BYTE_MSB:0] :
                                count_reg[`ISTIM_LOW_BYTE_MSB:0]};
    // Values below the least legal count are stored as that least count.
    assign count_next = (merged < MIN_VALUE) ? MIN_VALUE : merged;

    // ----------------------------------------
    // Storage.
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= RESET_VALUE;
        end else if (wr_en) begin
            count_reg <= count_next;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/istim_scl_timing.v ----
`timescale 1ns/1ps
`default_nettype none
`include "istim_consts.vh"

module istim_scl_timing #(
    parameter WIDTH = 16
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Register port.
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_addr,
    input wire [1:0] reg_be,
    input wire [WIDTH-1:0] reg_wdata,
    output reg [WIDTH-1:0] reg_rdata_reg,
    // Controls from the transfer logic.
    input wire controller_enable_bit,
    input wire speed_fast,
    input wire hs_preamble,
    input wire scl_run,
    // Bus pins.
    input wire scl_in,
    input wire sda_in,
    output reg scl_oe_reg,
    // Status.
    output reg scl_high_reg,
    output reg bus_idle_reg
);

    // ----------------------------------------
    // Address decode.
    // ----------------------------------------
    function [3:0] istim_decode;
        input [31:0] addr;
        begin
            istim_decode = {addr == `ISTIM_FAST_LOW_ADDR, addr == `ISTIM_FAST_HIGH_ADDR,
                            addr == `ISTIM_STD_LOW_ADDR, addr == `ISTIM_STD_HIGH_ADDR};
        end
    endfunction

    localparam [WIDTH*4-1:0] RESETS = {`ISTIM_FAST_LOW_RESET, `ISTIM_FAST_HIGH_RESET,
                                       `ISTIM_STD_LOW_RESET, `ISTIM_STD_HIGH_RESET};
    localparam [WIDTH*4-1:0] MINS = {`ISTIM_LOW_MIN, `ISTIM_HIGH_MIN,
                                     `ISTIM_LOW_MIN, `ISTIM_HIGH_MIN};

    wire [3:0] hit;
    wire [WIDTH*4-1:0] counts;
    wire [WIDTH-1:0] std_high_phase_count;
    wire [WIDTH-1:0] std_low_phase_count;
    wire [WIDTH-1:0] fast_high_phase_count;
    wire [WIDTH-1:0] fast_low_phase_count;

    assign hit = istim_decode(reg_addr);
    assign std_high_phase_count = counts[WIDTH-1:0];
    assign std_low_phase_count = counts[WIDTH*2-1:WIDTH];
    assign fast_high_phase_count = counts[WIDTH*3-1:WIDTH*2];
    assign fast_low_phase_count = counts[WIDTH*4-1:WIDTH*3];

    // ----------------------------------------
    // Count registers.
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_count
            istim_count_store #(
                .WIDTH(WIDTH),
                .RESET_VALUE(RESETS[WIDTH*gi+WIDTH-1:WIDTH*gi]),
                .MIN_VALUE(MINS[WIDTH*gi+WIDTH-1:WIDTH*gi])
            ) u_store (
                .clk_sys(clk_sys),
                .rst(rst),
                .wr_en(reg_wr & hit[gi] & ~controller_enable_bit),
                .wr_be(reg_be),
                .wr_data(reg_wdata),
                .count_reg(counts[WIDTH*gi+WIDTH-1:WIDTH*gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read back.
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_reg <= {WIDTH{1'b0}};
        end else if (reg_rd) begin
            case (hit)
                4'h1: reg_rdata_reg <= std_high_phase_count;
                4'h2: reg_rdata_reg <= std_low_phase_count;
                4'h4: reg_rdata_reg <= fast_high_phase_count;
                4'h8: reg_rdata_reg <= fast_low_phase_count;
                default: reg_rdata_reg <= {WIDTH{1'b0}};
            endcase
        end
    end

    // ----------------------------------------
    // Pin synchronisers.
    // ----------------------------------------
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;

    always @(posedge clk_sys) begin
        if (rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
        end
    end

    // ----------------------------------------
    // Phase count selection.
    // ----------------------------------------
    wire use_fast;
    wire [WIDTH-1:0] high_sel;
    wire [WIDTH-1:0] low_sel;

    assign use_fast = speed_fast | hs_preamble;
    assign high_sel = use_fast ? fast_high_phase_count : std_high_phase_count;
    assign low_sel = use_fast ? fast_low_phase_count : std_low_phase_count;

    // ----------------------------------------
    // Clock generator.
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_LOW = 3'h2;
    localparam [2:0] ST_HIGH = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [WIDTH-1:0] phase_reg;
    reg [WIDTH-1:0] phase_next;
    wire active;

    assign active = controller_enable_bit & scl_run;

    always @* begin
        state_next = state_reg;
        phase_next = phase_reg;
        case (state_reg)
            ST_IDLE: begin
                if (active) begin
                    state_next = ST_LOW;
                    phase_next = low_sel - 16'h0001;
                end
            end
            ST_LOW: begin
                if (phase_reg != {WIDTH{1'b0}}) begin
                    phase_next = phase_reg - 16'h0001;
                end else begin
                    state_next = ST_HIGH;
                    phase_next = high_sel - 16'h0001;
                end
            end
            ST_HIGH: begin
                if (phase_reg != {WIDTH{1'b0}}) begin
                    phase_next = phase_reg - 16'h0001;
                end else if (active) begin
                    state_next = ST_LOW;
                    phase_next = low_sel - 16'h0001;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                phase_next = {WIDTH{1'b0}};
            end
        endcase
        if (!controller_enable_bit) begin
            state_next = ST_IDLE;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            phase_reg <= {WIDTH{1'b0}};
            scl_oe_reg <= 1'b0;
            scl_high_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            scl_oe_reg <= (state_next == ST_LOW);
            scl_high_reg <= (state_next != ST_LOW);
        end
    end

    // ----------------------------------------
    // Bus idle detection.
    // ----------------------------------------
    reg [WIDTH-1:0] idle_cnt_reg;
    wire [WIDTH-1:0] idle_limit;
    wire bus_high;

    assign bus_high = scl_sync_reg[1] & sda_sync_reg[1];
    assign idle_limit = std_high_phase_count + `ISTIM_IDLE_MARGIN;

    always @(posedge clk_sys) begin
        if (rst) begin
            idle_cnt_reg <= {WIDTH{1'b0}};
            bus_idle_reg <= 1'b0;
        end else if (!bus_high) begin
            idle_cnt_reg <= {WIDTH{1'b0}};
            bus_idle_reg <= 1'b0;
        end else if (idle_cnt_reg >= idle_limit) begin
            bus_idle_reg <= 1'b1;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

endmodule
`default_nettype wire

// ---- sim/istim_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "istim_consts.vh"
// ----
// Checks on the timing block's ports.
// ----
module istim_props #(parameter int WIDTH = 16) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_addr,
    input wire logic [1:0] reg_be,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic [WIDTH-1:0] reg_rdata_reg,
    input wire logic controller_enable_bit,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe_reg,
    input wire logic scl_high_reg,
    input wire logic bus_idle_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] hi_cnt;
    always @(posedge clk_sys) begin
        hi_cnt <= (rst || !(scl_in && sda_in)) ? 16'h0000 : hi_cnt + 16'h0001;
    end
    sequence s_wr(a, lk);
        reg_wr && controller_enable_bit == lk && reg_be != 2'h0 && reg_addr == a;
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    property p_clamp(a, m);
        s_wr(a, 1'b0) ##0 (reg_be == 2'h3 && reg_wdata < m) ##2 s_rd(a) |=> reg_rdata_reg == m;
    endproperty
    AST_CLAMP_SH: assert property (p_clamp(`ISTIM_STD_HIGH_ADDR, 16'h0006))
        else $error("std high not clamped");
    AST_CLAMP_SL: assert property (p_clamp(`ISTIM_STD_LOW_ADDR, 16'h0008))
        else $error("std low not clamped");
    AST_CLAMP_FH: assert property (p_clamp(`ISTIM_FAST_HIGH_ADDR, 16'h0006))
        else $error("fast high not clamped");
    AST_CLAMP_FL: assert property (p_clamp(`ISTIM_FAST_LOW_ADDR, 16'h0008))
        else $error("fast low not clamped");
    AST_LOCK: assert property (reg_rd ##2 s_wr($past(reg_addr, 2), 1'b1)
        ##2 s_rd($past(reg_addr, 4)) |=> $stable(reg_rdata_reg)) else $error("locked write taken");
    AST_LOW_MIN: assert property ($rose(scl_oe_reg)
        |-> (scl_oe_reg || !$past(controller_enable_bit))[*8]) else $error("low phase short");
    AST_HIGH_MIN: assert property ($fell(scl_oe_reg) |-> (!scl_oe_reg)[*6])
        else $error("high phase short");
    AST_DIS: assert property (!controller_enable_bit |=> !scl_oe_reg)
        else $error("clock driven while disabled");
    AST_IDLE_CLR: assert property (!(scl_in && sda_in) |-> ##[1:4] !bus_idle_reg)
        else $error("idle kept with line low");
    AST_IDLE_MIN: assert property ($rose(bus_idle_reg) |-> hi_cnt > 16'h0010)
        else $error("idle too early");
    AST_HIGH_INV: assert property (scl_high_reg == !scl_oe_reg)
        else $error("released flag not the inverse of the drive");
endmodule
bind istim_scl_timing istim_props #(.WIDTH(WIDTH)) i_istim_props (
    .clk_sys(clk_sys),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_be(reg_be),
    .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg),
    .controller_enable_bit(controller_enable_bit),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe_reg(scl_oe_reg),
    .scl_high_reg(scl_high_reg),
    .bus_idle_reg(bus_idle_reg)
);
`default_nettype wire

// ---- sim/istim_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Open-drain lines with pull-ups, as the bus devices present them.
// ----
module istim_bus_model (
    input wire logic scl_oe_reg,
    input wire logic sda_low,
    output logic scl_in,
    output logic sda_in
);
    assign scl_in = !scl_oe_reg;
    assign sda_in = !sda_low;
endmodule
`default_nettype wire

// ---- sim/istim_scl_timing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "istim_consts.vh"
module istim_scl_timing_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sda_low = 1'b0;
    logic controller_enable_bit = 1'b0, speed_fast = 1'b0, hs_preamble = 1'b0, scl_run = 1'b0;
    logic [31:0] reg_addr = 32'h00000000;
    logic [1:0] reg_be = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_reg, hv, lv;
    logic scl_in, sda_in, scl_oe_reg, scl_high_reg, bus_idle_reg, rd_seen = 1'b0, last_oe = 1'b0;
    logic [15:0] exp_rd[$];
    int exp_ph[$];
    int bad_count = 0, compares = 0, cyc = 0, ph_len = 0, k;
    bit armed = 1'b0;
    logic [31:0] adr[4] = '{`ISTIM_STD_HIGH_ADDR, `ISTIM_STD_LOW_ADDR,
        `ISTIM_FAST_HIGH_ADDR, `ISTIM_FAST_LOW_ADDR};
    logic [15:0] rv[4] = '{`ISTIM_STD_HIGH_RESET, `ISTIM_STD_LOW_RESET,
        `ISTIM_FAST_HIGH_RESET, `ISTIM_FAST_LOW_RESET};
    logic [15:0] cin[4] = '{16'h0005, 16'h0007, 16'h0003, 16'h0000};
    logic [15:0] cout[4] = '{16'h0006, 16'h0008, 16'h0006, 16'h0008};
    istim_scl_timing i_istim_scl_timing (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_be(reg_be),
        .reg_wdata(reg_wdata),
        .reg_rdata_reg(reg_rdata_reg),
        .controller_enable_bit(controller_enable_bit),
        .speed_fast(speed_fast),
        .hs_preamble(hs_preamble),
        .scl_run(scl_run),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_oe_reg(scl_oe_reg),
        .scl_high_reg(scl_high_reg),
        .bus_idle_reg(bus_idle_reg)
    );
    istim_bus_model i_istim_bus_model (
        .scl_oe_reg(scl_oe_reg),
        .sda_low(sda_low),
        .scl_in(scl_in),
        .sda_in(sda_in)
    );
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [1:0] b, logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_be <= b;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [31:0] a, logic [15:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_rd.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    always @(posedge clk_sys) begin
        if (rd_seen) chk("rdata", exp_rd.pop_front(), reg_rdata_reg);
        rd_seen = reg_rd;
        if (scl_oe_reg !== last_oe) begin
            if (armed && exp_ph.size() > 0) begin
                chk("phase", 16'(exp_ph.pop_front()), 16'(ph_len));
            end
            armed = 1'b1;
            ph_len = 0;
        end
        if (!controller_enable_bit) armed = 1'b0;
        ph_len++;
        last_oe = scl_oe_reg;
    end
    initial begin
        void'($urandom(21));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (adr[i]) rd(adr[i], rv[i]);
        foreach (adr[i]) begin
            wr(adr[i], 2'h3, cin[i]);
            rd(adr[i], cout[i]);
        end
        wr(adr[1], 2'h1, 16'h0034);
        wr(adr[1], 2'h2, 16'h1200);
        rd(adr[1], 16'h1234);
        wr(32'h50001324, 2'h3, 16'hFFFF);
        rd(32'h50001324, 16'h0000);
        controller_enable_bit <= 1'b1;
        rd(adr[0], 16'h0006);
        wr(adr[0], 2'h3, 16'($urandom));
        rd(adr[0], 16'h0006);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_sys);
            controller_enable_bit <= 1'b0;
            scl_run <= 1'b0;
            hv = (m == 0) ? 16'h0014 : 16'h0006 + 16'($urandom % 10);
            lv = 16'h0008 + 16'(3 * m);
            wr(adr[(m == 0) ? 0 : 2], 2'h3, hv);
            wr(adr[(m == 0) ? 1 : 3], 2'h3, lv);
            speed_fast <= (m == 1);
            hs_preamble <= (m == 2);
            exp_ph.push_back(int'(lv));
            exp_ph.push_back(int'(hv));
            exp_ph.push_back(int'(lv));
            @(posedge clk_sys);
            controller_enable_bit <= 1'b1;
            scl_run <= 1'b1;
            while (exp_ph.size() > 0) @(posedge clk_sys);
        end
        controller_enable_bit <= 1'b0;
        scl_run <= 1'b0;
        sda_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("idle_low", 16'h0000, 16'(bus_idle_reg));
        sda_low <= 1'b0;
        for (k = 0; k < 100 && bus_idle_reg !== 1'b1; k++) @(posedge clk_sys);
        chk("idle_delay", 16'h0001, 16'(k >= 30 && k <= 36));
        repeat (4) @(posedge clk_sys);
        report_and_stop();
    end
endmodule
`default_nettype wire
